// ---- logic/otc_pkg.sv ----
// constants and register map for the oscillator timer and clock output block
package otc_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_SETPT = 8'h08;
  localparam logic [7:0] ADDR_CLKCFG = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // timer_control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_INV_BIT = 1;
  localparam int unsigned CTRL_SEL_LO = 2;
  // clock config fields
  localparam int unsigned CLKCFG_SEL_LO = 0;
  localparam int unsigned CLKCFG_MODE_BIT = 4;
  localparam logic [3:0] PIN_OFF = 4'h0;
  localparam logic [3:0] PIN_TIMER = 4'hf;
  // status fields
  localparam int unsigned ST_HALF_BIT = 0;
  localparam int unsigned ST_SLOW_BIT = 1;
  localparam int unsigned ST_OUT_BIT = 2;
  localparam int unsigned ST_ADC_BIT = 3;
  // timer clock selections
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_OSC = 2'h1;
  localparam logic [1:0] SEL_KHZ = 2'h2;
  localparam logic [1:0] SEL_HZ = 2'h3;
  // oscillator 1.2288 MHz; divisions for the slower timer clocks
  localparam real OSC_HZ = 1228800.0;
  localparam real KHZ_HZ = 1200.0;
  localparam int unsigned DIV_KHZ = 1024;
  localparam int unsigned DIV_HZ = 1048576;
  localparam int unsigned DIV_SLOW_FLAG = 1024;
  localparam int unsigned PRESCALE_W = 20;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_SETPT = 16'h8000;
endpackage

// ---- logic/otc_top.sv ----
// oscillator timer, clock output pin mux and divided-oscillator status with APB access
`timescale 1ns/1ns
module otc_top #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned ADC_DIV = 320
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CS_N,
  output logic SPI_STATUS_BIT,
  output logic UART_STATUS_BIT,
  output logic CLK_OUT,
  output logic CLK_OUT_OE,
  output logic TIMER_OUT,
  output logic ADC_START
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] setpt;
    logic [15:0] clkcfg;
    logic [otc_pkg::PRESCALE_W-1:0] osc_div;
    logic [CNT_W-1:0] count;
    logic tmr;
    logic [14:0] pin_div;
    logic [15:0] adc_cnt;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic spi_bit;
    logic uart_bit;
    logic clk_out;
    logic clk_oe;
    logic tout;
    logic adc;
  } otc_state_t;

  otc_state_t s_q;
  otc_state_t s_d;

  logic [1:0] sel;
  logic inv;
  logic en;
  logic [3:0] pin_sel;
  logic half_flag;
  logic slow_flag;
  logic tick;
  logic access;
  logic wr;
  logic known;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  always_comb begin
    sel = s_q.ctrl[otc_pkg::CTRL_SEL_LO +: 2];
    inv = s_q.ctrl[otc_pkg::CTRL_INV_BIT];
    en = s_q.ctrl[otc_pkg::CTRL_EN_BIT];
    pin_sel = s_q.clkcfg[otc_pkg::CLKCFG_SEL_LO +: 4];
    half_flag = s_q.osc_div[0];
    slow_flag = s_q.osc_div[$clog2(otc_pkg::DIV_SLOW_FLAG)-1];
    // one oscillator cycle wide strobe of the chosen timer clock
    unique case (sel)
      otc_pkg::SEL_OSC: tick = 1'b1;
      otc_pkg::SEL_KHZ: tick = (s_q.osc_div[$clog2(otc_pkg::DIV_KHZ)-1:0] == '0);
      otc_pkg::SEL_HZ: tick = (s_q.osc_div == '0);
      default: tick = 1'b0;
    endcase
    access = PSEL && PENABLE;
    wr = access && PWRITE;
    known = (PADDR == otc_pkg::ADDR_CTRL) || (PADDR == otc_pkg::ADDR_PERIOD) ||
            (PADDR == otc_pkg::ADDR_SETPT) || (PADDR == otc_pkg::ADDR_CLKCFG) ||
            (PADDR == otc_pkg::ADDR_STATUS);
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{PSTRB[i]}};
    end
    rd_val = '0;
    unique case (PADDR)
      otc_pkg::ADDR_CTRL: rd_val[15:0] = s_q.ctrl;
      otc_pkg::ADDR_PERIOD: rd_val[CNT_W-1:0] = s_q.period;
      otc_pkg::ADDR_SETPT: rd_val[CNT_W-1:0] = s_q.setpt;
      otc_pkg::ADDR_CLKCFG: rd_val[15:0] = s_q.clkcfg;
      otc_pkg::ADDR_STATUS: begin
        rd_val[otc_pkg::ST_HALF_BIT] = half_flag;
        rd_val[otc_pkg::ST_SLOW_BIT] = slow_flag;
        rd_val[otc_pkg::ST_OUT_BIT] = s_q.tout;
        rd_val[otc_pkg::ST_ADC_BIT] = s_q.adc;
      end
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // free-running oscillator divider chain
    s_d.osc_div = s_q.osc_div + 1'b1;
    s_d.cs_s1 = CS_N;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_s3 = s_q.cs_s2;

    // APB slave: one-wait-state answer in the access phase
    s_d.ready = 1'b0;
    s_d.slverr = 1'b0;
    if (access && !s_q.ready) begin
      s_d.ready = 1'b1;
      s_d.slverr = !known;
      s_d.rdata = PWRITE ? '0 : rd_val;
      if (wr && known) begin
        unique case (PADDR)
          otc_pkg::ADDR_CTRL: s_d.ctrl = (s_q.ctrl & ~wmask[15:0]) | (PWDATA[15:0] & wmask[15:0]);
          otc_pkg::ADDR_PERIOD: s_d.period = CNT_W'((s_q.period & ~wmask[CNT_W-1:0]) |
                                             (PWDATA[CNT_W-1:0] & wmask[CNT_W-1:0]));
          otc_pkg::ADDR_SETPT: s_d.setpt = CNT_W'((s_q.setpt & ~wmask[CNT_W-1:0]) |
                                           (PWDATA[CNT_W-1:0] & wmask[CNT_W-1:0]));
          otc_pkg::ADDR_CLKCFG: s_d.clkcfg = (s_q.clkcfg & ~wmask[15:0]) |
                                             (PWDATA[15:0] & wmask[15:0]);
          default: s_d.ctrl = s_q.ctrl;
        endcase
      end
    end

    // timer: disabled resets count; no clock freezes it
    if (!en) begin
      s_d.count = '0;
      s_d.tmr = 1'b0;
    end else if (tick) begin
      if (s_q.count >= s_q.period) begin
        s_d.count = '0; // period + 1 ticks
        s_d.tmr = 1'b0;
      end else begin
        s_d.count = s_q.count + 1'b1;
        // rises once the set point has been reached: high for period minus set point ticks
        if (s_q.count == s_q.setpt) begin
          s_d.tmr = 1'b1;
        end
      end
    end
    s_d.tout = s_q.tmr ^ inv;

    // clock pin mux
    s_d.pin_div = s_q.pin_div + 1'b1;
    s_d.clk_oe = (pin_sel != otc_pkg::PIN_OFF);
    if (pin_sel == otc_pkg::PIN_TIMER) begin
      s_d.clk_out = s_q.tmr ^ inv;
    end else if (pin_sel == otc_pkg::PIN_OFF) begin
      s_d.clk_out = 1'b0;
    end else begin
      s_d.clk_out = s_q.pin_div[pin_sel - 4'h1];
    end

    // status bits: SPI half-rate latched at chip-select fall
    if (s_q.cs_s3 && !s_q.cs_s2) begin
      s_d.spi_bit = half_flag;
    end
    s_d.uart_bit = s_q.clkcfg[otc_pkg::CLKCFG_MODE_BIT] ? slow_flag : 1'b0;

    // conversion pacing from the oscillator
    s_d.adc = 1'b0;
    if (s_q.adc_cnt >= 16'(ADC_DIV - 1)) begin
      s_d.adc_cnt = '0;
      s_d.adc = 1'b1;
    end else begin
      s_d.adc_cnt = s_q.adc_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.ctrl <= otc_pkg::RST_CTRL;
      s_q.period <= CNT_W'(otc_pkg::RST_PERIOD);
      s_q.setpt <= CNT_W'(otc_pkg::RST_SETPT);
      s_q.cs_s1 <= 1'b1;
      s_q.cs_s2 <= 1'b1;
      s_q.cs_s3 <= 1'b1;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.rdata;
  assign PREADY = s_q.ready;
  assign PSLVERR = s_q.slverr;
  assign SPI_STATUS_BIT = s_q.spi_bit;
  assign UART_STATUS_BIT = s_q.uart_bit;
  assign CLK_OUT = s_q.clk_out;
  assign CLK_OUT_OE = s_q.clk_oe;
  assign TIMER_OUT = s_q.tout;
  assign ADC_START = s_q.adc;
endmodule

// ---- sim/otc_host_model.sv ----
// controller model: polls the spi status bit and counts clock pin rises
`timescale 1ns/1ns
module otc_host_model (
  input wire logic clk,
  input wire logic spi_bit,
  input wire logic pin,
  input wire logic oe,
  output logic cs_n,
  output int stuck,
  output int edges
);
  int t = 0;
  logic last = 1'b0, pin_l = 1'b0;
  initial {cs_n, stuck, edges} = {1'b1, 32'h0, 32'h0};
  always @(posedge clk) begin
    t <= t == 8 ? 0 : t + 1;
    cs_n <= t > 2; // odd frame spacing so each poll sees the flag flip
    if (t == 8) begin
      last <= spi_bit;
      stuck <= stuck + int'(spi_bit == last);
    end
    pin_l <= pin;
    if (oe && pin && !pin_l) edges <= edges + 1;
  end
endmodule

// ---- sim/otc_properties.sv ----
// port assertions for the oscillator timer block
`timescale 1ns/1ns
module otc_properties (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CS_N,
  input wire logic SPI_STATUS_BIT,
  input wire logic UART_STATUS_BIT,
  input wire logic CLK_OUT,
  input wire logic CLK_OUT_OE,
  input wire logic TIMER_OUT,
  input wire logic ADC_START,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB
);
  logic [4:0] cfg_q, cfg_p;
  // shadow of the clock config register, and its value one cycle back
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N) {cfg_q, cfg_p} <= 10'h0;
    else begin
      cfg_p <= cfg_q;
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h0c && PSTRB[0])
        cfg_q <= PWDATA[4:0];
    end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_apb_answer: assert property (PSEL && PENABLE && !PREADY && CLK_EN |=> PREADY)
    else $error("access not answered in one cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_unmapped_err: assert property (PREADY && PADDR > 8'h10 |-> PSLVERR)
    else $error("no error on unmapped address");
  a_pin_timer: assert property (cfg_q[3:0] == 4'hf && cfg_p[3:0] == 4'hf |->
    CLK_OUT_OE && CLK_OUT == TIMER_OUT) else $error("pin does not carry timer");
  a_pin_off: assert property (cfg_q[3:0] == 4'h0 && cfg_p[3:0] == 4'h0 |-> !CLK_OUT_OE)
    else $error("pin driven while off");
  a_uart_quiet: assert property (!cfg_q[4] && !cfg_p[4] |-> !UART_STATUS_BIT)
    else $error("slow flag outside uart mode");
  a_frozen_out: assert property (!CLK_EN |=> $stable(TIMER_OUT) && $stable(CLK_OUT))
    else $error("output moved while frozen");
  a_spi_hold: assert property (CS_N [*6] |=> $stable(SPI_STATUS_BIT))
    else $error("half rate flag moved without select fall");
  a_adc_gap: assert property ($rose(ADC_START) |=> !$rose(ADC_START) [*8])
    else $error("adc starts too close");
endmodule
bind otc_top otc_properties i_otc_properties (.*);

// ---- sim/test_oscillator_timer_clock_output.sv ----
// self-checking bench for the oscillator timer block
`timescale 1ns/1ns
module test_oscillator_timer_clock_output;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PREADY, PSLVERR, CS_N, SPI_STATUS_BIT, UART_STATUS_BIT;
  logic CLK_OUT, CLK_OUT_OE, TIMER_OUT, ADC_START;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'hf;
  logic [16:0] exp_q[$];
  int fail_count = 0, cmp_count = 0, stuck, edges, e0, n;
  integer seed = 32'hbafd;
  otc_top i_otc_top (.*);
  otc_host_model i_otc_host_model (.clk(CLK_SYS), .spi_bit(SPI_STATUS_BIT), .pin(CLK_OUT),
    .oe(CLK_OUT_OE), .cs_n(CS_N), .stuck(stuck), .edges(edges));
  initial forever #50 CLK_SYS = ~CLK_SYS;
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int k = 0;
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, 16'h0, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      k++;
    end while (PREADY !== 1'b1 && k < 99);
    if (k >= 99) begin
      fail_count++;
      results;
    end
    {PSEL, PENABLE} <= 2'h0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a, input logic [16:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 16'h0);
  endtask
  // counts rising edges of the timer output or of the slow flag over c cycles
  task automatic span(input int c, input bit u, input int want);
    logic p, v;
    int r = 0;
    p = u ? UART_STATUS_BIT : TIMER_OUT;
    repeat (c) begin
      @(posedge CLK_SYS);
      v = u ? UART_STATUS_BIT : TIMER_OUT;
      r += int'(v && !p);
      p = v;
    end
    check(17'(r), 17'(want));
  endtask
  // counts cycles with the timer output high over c cycles
  task automatic duty(input int c, input int want);
    int h = 0;
    repeat (c) begin
      @(posedge CLK_SYS);
      h += int'(TIMER_OUT === 1'b1);
    end
    check(17'(h), 17'(want));
  endtask
  always @(posedge CLK_SYS)
    if (PREADY === 1'b1 && PWRITE === 1'b0 && exp_q.size() > 0)
      check({PSLVERR, PSLVERR ? 16'h0 : PRDATA[15:0]}, exp_q.pop_front());
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(8'h04, 17'hffff);
    rd(8'h08, 17'h8000);
    rd(8'h20, 17'h10000);
    repeat (3) begin
      n = $random(seed);
      apb(1'b1, 8'h08, n[15:0]);
      rd(8'h08, {1'b0, n[15:0]});
    end
    e0 = stuck;
    repeat (99) @(posedge CLK_SYS);
    check(17'(stuck - e0), 17'h0);
    check({16'h0, TIMER_OUT}, 17'h0);
    apb(1'b1, 8'h00, 16'h2);
    repeat (3) @(posedge CLK_SYS);
    check({16'h0, TIMER_OUT}, 17'h1);
    apb(1'b1, 8'h00, 16'h0);
    apb(1'b1, 8'h04, 16'h4);
    apb(1'b1, 8'h08, 16'h1);
    apb(1'b1, 8'h00, 16'h5);
    repeat (9) @(posedge CLK_SYS);
    span(50, 0, 10);
    duty(50, 30);
    apb(1'b1, 8'h00, 16'h0);
    apb(1'b1, 8'h04, 16'h1);
    apb(1'b1, 8'h08, 16'h0);
    apb(1'b1, 8'h00, 16'h9);
    repeat (2100) @(posedge CLK_SYS);
    span(4096, 0, 2);
    apb(1'b1, 8'h00, 16'h1);
    span(99, 0, 0);
    apb(1'b1, 8'h00, 16'hd);
    span(99, 0, 0);
    apb(1'b1, 8'h00, 16'h5);
    apb(1'b1, 8'h0c, 16'hf);
    repeat (3) @(posedge CLK_SYS);
    check({16'h0, CLK_OUT_OE}, 17'h1);
    repeat (200) begin
      @(posedge CLK_SYS);
      n = $random(seed);
      CLK_EN <= n[0];
    end
    @(posedge CLK_SYS);
    CLK_EN <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, 8'h0c, 16'(i));
      repeat (9) @(posedge CLK_SYS);
      e0 = edges;
      repeat (64) @(posedge CLK_SYS);
      check(17'(edges - e0), 17'(64 >> i));
    end
    apb(1'b1, 8'h0c, 16'h10);
    span(4096, 1, 4);
    results;
  end
endmodule
